/* File: verilog/tss_top.sv */
// Two-speed clock start-up sequencer
`timescale 1ns/1ps
`default_nettype none
`include "tss_regs.svh"

// Notes on behaviour
// - Crystal-type modes wait 1024 oscillator cycles before that clock is used.
// - Dual-speed start-up stays off for every non-crystal oscillator mode.
// - External clock modes skip the start-up count after reset or wake.
// - While the crystal settles in dual-speed start-up, instructions run from the internal oscillator.
// - Count completing before sleep sets the done flag and moves to external clock.
// - Sleep aborts the start-up wait and leaves the done flag clear.
// - Dual-speed needs switchover fuse 1, clock select 00 and crystal mode.
// - Sequence starts after power-on (and power-up timer) and on every wake.
// - Internal oscillator is used only after its warm-up delay.
// - Timer1 or crystal oscillator is used only after 1024 counted cycles.
module tss_top #(
	parameter int unsigned OST_LIMIT = `TSS_OST_COUNT,
	parameter int unsigned OST_W     = `TSS_OST_W,
	parameter int unsigned WARM_W    = `TSS_WARM_W
) (
	// Clock, reset, enable
	input  wire logic           mclk,
	input  wire logic           rstn,
	input  wire logic           ce,
	// Power-on and sleep events
	input  wire logic           por_done,
	input  wire logic           power_up_timer_en,
	input  wire logic           power_up_timer_expired,
	input  wire logic           sleep_exec,
	input  wire logic           wake_event,
	// Configuration
	input  wire logic           switchover_enable,
	input  wire logic [2:0]     oscillator_mode_field,
	input  wire logic [1:0]     clock_select_field,
	// Oscillator cycle ticks
	input  wire logic           ext_osc_tick,
	input  wire logic           t1_osc_tick,
	// Clock selection and status
	output var  tss_pkg::tss_src_t sys_clk_src,
	output logic                core_run,
	output logic                ext_osc_en,
	output logic                two_speed_active,
	output logic                start_up_done_flag
);

	localparam int unsigned WARM_CYC =
		(`TSS_TWARM_NS * 1000 + `TSS_CLK_PS - 1) / `TSS_CLK_PS;
	localparam logic [WARM_W-1:0] WARM_LOAD = WARM_W'(WARM_CYC);
	localparam logic [WARM_W-1:0] EC_LOAD   = WARM_W'(`TSS_EC_CYCLES);

	if (WARM_CYC < 1 || WARM_CYC >= (1 << WARM_W)
		|| `TSS_EC_CYCLES >= (1 << WARM_W)) begin : g_bad_warm
		$error("tss_top: warm-up count does not fit in WARM_W bits");
	end

	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	tss_pkg::tss_state_t state_ff;
	tss_pkg::tss_state_t nxt_state;
	tss_pkg::tss_src_t   target_ff;
	tss_pkg::tss_src_t   src_ff;
	logic                use_ost_ff;
	logic [WARM_W-1:0]   warm_cnt_ff;
	logic                run_ff;
	logic                ext_en_ff;
	logic                ts_active_ff;
	logic                done_flag_ff;

	tss_pkg::tss_state_t sel_state;
	tss_pkg::tss_src_t   sel_target;
	logic                sel_ost;
	logic [WARM_W-1:0]   sel_load;

	logic crystal_mode;
	logic ts_en;
	logic por_ok;
	logic start_go;
	logic sleep_go;
	logic warm_zero;
	logic wait_done;
	logic ost_hit;

	tss_ost_if #(.W(OST_W)) ost_bus ();

	tss_ost #(
		.LIMIT (OST_LIMIT),
		.W     (OST_W)
	) u_ost (
		.mclk  (mclk),
		.rstn  (rstn),
		.ce    (ce),
		.ost   (ost_bus)
	);

	// ----------------------------------------------------------------------
	// Start conditions
	// ----------------------------------------------------------------------
	assign crystal_mode = oscillator_mode_field == `TSS_MODE_LP
		|| oscillator_mode_field == `TSS_MODE_XT
		|| oscillator_mode_field == `TSS_MODE_HS;
	assign ts_en = switchover_enable && clock_select_field == `TSS_CS_PRIMARY
		&& crystal_mode;
	assign por_ok = por_done && (!power_up_timer_en || power_up_timer_expired);
	assign start_go = ce && ((state_ff == tss_pkg::st_off && por_ok)
		|| (state_ff == tss_pkg::st_sleep && wake_event));
	// Sleep can only be executed while the core runs
	assign sleep_go = ce && sleep_exec
		&& (state_ff == tss_pkg::st_int || state_ff == tss_pkg::st_ext);
	assign warm_zero = warm_cnt_ff == '0;
	assign wait_done = use_ost_ff ? ost_bus.done : warm_zero;
	assign ost_hit = state_ff == tss_pkg::st_int && use_ost_ff && ost_bus.done;

	// Path chosen at each start from the live configuration
	always_comb begin
		sel_state  = tss_pkg::st_warm;
		sel_target = tss_pkg::src_int;
		sel_ost    = 1'b0;
		sel_load   = WARM_LOAD;
		if (clock_select_field[`TSS_CS_INT_BIT]) begin
			sel_target = tss_pkg::src_int;
		end else if (clock_select_field == `TSS_CS_TIMER1) begin
			sel_state  = tss_pkg::st_waitx;
			sel_target = tss_pkg::src_t1;
			sel_ost    = 1'b1;
		end else if (crystal_mode) begin
			sel_target = tss_pkg::src_ext;
			sel_ost    = 1'b1;
			if (!ts_en) begin
				sel_state = tss_pkg::st_waitx;
			end
		end else if (oscillator_mode_field != `TSS_MODE_INT) begin
			sel_state  = tss_pkg::st_waitx;
			sel_target = tss_pkg::src_ext;
			sel_load   = EC_LOAD;
		end
	end

	// ----------------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			tss_pkg::st_off: begin
				if (start_go) nxt_state = sel_state;
			end
			tss_pkg::st_warm: begin
				if (warm_zero) nxt_state = tss_pkg::st_int;
			end
			tss_pkg::st_int: begin
				// Sleep in the same cycle as the last count wins
				if (sleep_go) nxt_state = tss_pkg::st_sleep;
				else if (ost_hit) nxt_state = tss_pkg::st_swap;
			end
			tss_pkg::st_waitx: begin
				if (wait_done) nxt_state = tss_pkg::st_ext;
			end
			tss_pkg::st_swap: begin
				nxt_state = tss_pkg::st_ext;
			end
			tss_pkg::st_ext: begin
				if (sleep_go) nxt_state = tss_pkg::st_sleep;
			end
			tss_pkg::st_sleep: begin
				if (start_go) nxt_state = sel_state;
			end
			default: begin
				nxt_state = tss_pkg::st_off;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) state_ff <= tss_pkg::st_off;
		else if (ce) state_ff <= nxt_state;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			target_ff  <= tss_pkg::src_none;
			use_ost_ff <= 1'b0;
		end else if (start_go) begin
			target_ff  <= sel_target;
			use_ost_ff <= sel_ost;
		end
	end

	// Warm-up counts mclk; the external-clock delay counts its own ticks
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			warm_cnt_ff <= `TSS_RST_WARM;
		end else if (ce) begin
			if (start_go) begin
				warm_cnt_ff <= sel_load;
			end else if (!warm_zero && (state_ff == tss_pkg::st_warm
				|| (state_ff == tss_pkg::st_waitx && ext_osc_tick))) begin
				warm_cnt_ff <= warm_cnt_ff - 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Start-up timer control
	// ----------------------------------------------------------------------
	assign ost_bus.clr  = start_go || sleep_go;
	assign ost_bus.run  = use_ost_ff
		&& (state_ff == tss_pkg::st_int || state_ff == tss_pkg::st_waitx);
	assign ost_bus.tick = (target_ff == tss_pkg::src_t1) ? t1_osc_tick : ext_osc_tick;

	// ----------------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------------
	// Swap state sends no clock for a cycle: break before make
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			src_ff <= tss_pkg::src_none;
			run_ff <= 1'b0;
		end else if (ce) begin
			case (nxt_state)
				tss_pkg::st_int: begin
					src_ff <= tss_pkg::src_int;
					run_ff <= 1'b1;
				end
				tss_pkg::st_ext: begin
					src_ff <= target_ff;
					run_ff <= 1'b1;
				end
				default: begin
					src_ff <= tss_pkg::src_none;
					run_ff <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ext_en_ff    <= 1'b0;
			ts_active_ff <= 1'b0;
		end else if (ce) begin
			ext_en_ff    <= nxt_state != tss_pkg::st_off && nxt_state != tss_pkg::st_sleep
				&& (start_go ? sel_target : target_ff) != tss_pkg::src_int;
			ts_active_ff <= (nxt_state == tss_pkg::st_warm || nxt_state == tss_pkg::st_int)
				&& (start_go ? sel_ost : use_ost_ff);
		end
	end

	// Cleared only at a new start, so an aborted wait leaves it clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			done_flag_ff <= `TSS_RST_FLAG;
		end else if (ce) begin
			if (start_go) begin
				done_flag_ff <= 1'b0;
			end else if (nxt_state == tss_pkg::st_swap || (state_ff == tss_pkg::st_waitx
				&& wait_done && use_ost_ff && target_ff == tss_pkg::src_ext)) begin
				done_flag_ff <= 1'b1;
			end
		end
	end

	assign sys_clk_src        = src_ff;
	assign core_run           = run_ff;
	assign ext_osc_en         = ext_en_ff;
	assign two_speed_active   = ts_active_ff;
	assign start_up_done_flag = done_flag_ff;

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_ost_hit;
		ce && ost_hit && !sleep_exec;
	endsequence

	sequence s_enter_int;
		state_ff == tss_pkg::st_int && $past(state_ff) == tss_pkg::st_warm;
	endsequence

	property p_ts_off;
		start_go && !ts_en |=> !ts_active_ff;
	endproperty
	a_ts_off: assert property (p_ts_off) else $error("two-speed without config");

	property p_ec_direct;
		start_go && clock_select_field == `TSS_CS_PRIMARY && !crystal_mode
			&& oscillator_mode_field != `TSS_MODE_INT |=> !use_ost_ff && warm_cnt_ff == EC_LOAD;
	endproperty
	a_ec_direct: assert property (p_ec_direct) else $error("external clock counted");

	property p_int_exec;
		state_ff == tss_pkg::st_int |-> sys_clk_src == tss_pkg::src_int && core_run;
	endproperty
	a_int_exec: assert property (p_int_exec) else $error("not on internal clock");

	property p_done_swap;
		s_ost_hit |=> state_ff == tss_pkg::st_swap && start_up_done_flag
			&& sys_clk_src == tss_pkg::src_none;
	endproperty
	a_done_swap: assert property (p_done_swap) else $error("no switch after count");

	property p_swap_ext;
		s_ost_hit ##1 ce |=> sys_clk_src == tss_pkg::src_ext && core_run;
	endproperty
	a_swap_ext: assert property (p_swap_ext) else $error("external clock not taken");

	property p_sleep_abort;
		sleep_go && state_ff == tss_pkg::st_int |=> (!start_up_done_flag && !core_run) [*2];
	endproperty
	a_sleep_abort: assert property (p_sleep_abort) else $error("sleep did not abort");

	property p_ts_cfg;
		start_go && ts_en |=> state_ff == tss_pkg::st_warm && use_ost_ff
			&& two_speed_active;
	endproperty
	a_ts_cfg: assert property (p_ts_cfg) else $error("two-speed not entered");

	property p_wake;
		ce && state_ff == tss_pkg::st_sleep && wake_event |=> state_ff != tss_pkg::st_sleep
			&& ost_bus.count == '0 && !start_up_done_flag;
	endproperty
	a_wake: assert property (p_wake) else $error("wake did not restart");

	property p_warm;
		s_enter_int |-> $past(warm_cnt_ff) == '0;
	endproperty
	a_warm: assert property (p_warm) else $error("internal clock before warm-up");

	property p_ost_wait;
		state_ff == tss_pkg::st_ext && $past(state_ff) == tss_pkg::st_waitx
			&& $past(use_ost_ff) |-> $past(ost_bus.done);
	endproperty
	a_ost_wait: assert property (p_ost_wait) else $error("oscillator used early");

	property p_no_overlap;
		$changed(sys_clk_src) |-> $past(sys_clk_src) == tss_pkg::src_none
			|| sys_clk_src == tss_pkg::src_none;
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("clock switched live");

endmodule : tss_top

`default_nettype wire

/* File: verilog/tss_regs.svh */
// Timing counts, field codes and reset values of the start-up sequencer
`ifndef TSS_REGS_SVH
`define TSS_REGS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TSS_CLK_PS       25000
`define TSS_OST_COUNT    1024
`define TSS_OST_W        11
`define TSS_TWARM_NS     2000
`define TSS_EC_CYCLES    2
`define TSS_WARM_W       8

// ----------------------------------------------------------------------
// Oscillator mode field codes
// ----------------------------------------------------------------------
`define TSS_MODE_LP      3'h0
`define TSS_MODE_XT      3'h1
`define TSS_MODE_HS      3'h2
`define TSS_MODE_RC      3'h3
`define TSS_MODE_INT     3'h4

// ----------------------------------------------------------------------
// Clock select field
// ----------------------------------------------------------------------
`define TSS_CS_PRIMARY   2'h0
`define TSS_CS_TIMER1    2'h1
`define TSS_CS_INT_BIT   1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TSS_RST_FLAG     1'h0
`define TSS_RST_WARM     8'h00

`endif

/* File: verilog/tss_pkg.sv */
// Types shared by the start-up sequencer
`default_nettype none

package tss_pkg;

	typedef enum logic [2:0] {
		st_off   = 3'h0,
		st_warm  = 3'h1,
		st_int   = 3'h2,
		st_waitx = 3'h3,
		st_ext   = 3'h4,
		st_sleep = 3'h5,
		st_swap  = 3'h6
	} tss_state_t;

	typedef enum logic [1:0] {
		src_none = 2'h0,
		src_int  = 2'h1,
		src_ext  = 2'h2,
		src_t1   = 2'h3
	} tss_src_t;

endpackage : tss_pkg

`default_nettype wire

/* File: verilog/tss_ost_if.sv */
// Link between the sequencer and its start-up timer
`timescale 1ns/1ps
`default_nettype none
`include "tss_regs.svh"

interface tss_ost_if #(
	parameter int unsigned W = `TSS_OST_W
) ();
	logic         clr;
	logic         run;
	logic         tick;
	logic         done;
	logic [W-1:0] count;

	modport ctl (output clr, output run, output tick, input done, input count);
	modport tmr (input clr, input run, input tick, output done, output count);
endinterface : tss_ost_if

`default_nettype wire

/* File: verilog/tss_ost.sv */
// Start-up timer: counts oscillator cycles up to a fixed limit
`timescale 1ns/1ps
`default_nettype none
`include "tss_regs.svh"

module tss_ost #(
	parameter int unsigned LIMIT = `TSS_OST_COUNT,
	parameter int unsigned W     = `TSS_OST_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	// Sequencer side
	tss_ost_if.tmr   ost
);

	localparam logic [W-1:0] LIM    = W'(LIMIT);
	localparam logic [W-1:0] LIM_M1 = W'(LIMIT - 1);

	if (LIMIT < 1 || LIMIT >= (1 << W)) begin : g_bad_limit
		$error("tss_ost: LIMIT does not fit in W bits");
	end

	logic [W-1:0] count_ff;

	// Saturates at the limit so done stays up until the next clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count_ff <= '0;
		end else if (ce) begin
			if (ost.clr) begin
				count_ff <= '0;
			end else if (ost.run && ost.tick && count_ff != LIM) begin
				count_ff <= count_ff + 1'b1;
			end
		end
	end

	assign ost.count = count_ff;
	assign ost.done  = (count_ff == LIM);

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	property p_ost_limit;
		@(posedge mclk) disable iff (!rstn)
		$rose(ost.done) |-> $past(count_ff) == LIM_M1 && $past(ost.tick);
	endproperty
	a_ost_limit: assert property (p_ost_limit) else $error("timer done early");

	property p_ost_clear;
		@(posedge mclk) disable iff (!rstn)
		ce && ost.clr |=> count_ff == '0 && !ost.done;
	endproperty
	a_ost_clear: assert property (p_ost_clear) else $error("timer not cleared");

endmodule : tss_ost

`default_nettype wire

/* File: sim/tss_osc_model.sv */
// Stand-in for the crystal and timer oscillators: one tick per oscillator cycle
`timescale 1ns/1ps
`default_nettype none

module tss_osc_model (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rstn,
	// Control
	input  wire logic en,
	input  wire logic free_run,
	input  wire logic slow,
	// Oscillator output
	output logic      tick
);
	logic [1:0] div_ff;

	// Unpowered crystal gives nothing; slow mode ticks every third cycle
	always @(negedge mclk or negedge rstn) begin
		if (!rstn) begin
			div_ff <= 2'h0;
			tick   <= 1'b0;
		end else if (en || free_run) begin
			div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
			tick   <= !slow || (div_ff == 2'h2);
		end else begin
			div_ff <= 2'h0;
			tick   <= 1'b0;
		end
	end
endmodule : tss_osc_model

`default_nettype wire

/* File: sim/tb_two_speed_clock_startup.sv */
// Self-checking bench for the two-speed clock start-up sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_two_speed_clock_startup;
	// Short start-up count keeps the run brief
	localparam int unsigned LIM = 8;

	logic              mclk       = 1'b0;
	logic              rstn       = 1'b0;
	logic              ce         = 1'b1;
	logic              por_done   = 1'b0;
	logic              pwr_en     = 1'b0;
	logic              pwr_exp    = 1'b0;
	logic              sleep_exec = 1'b0;
	logic              wake_event = 1'b0;
	logic              sw_en      = 1'b0;
	logic [2:0]        mode       = 3'h1;
	logic [1:0]        cs         = 2'h0;
	logic              free       = 1'b0;
	logic              slow       = 1'b0;
	logic              ext_tick, t1_tick, core_run, ext_osc_en, ts_active, done_flag;
	tss_pkg::tss_src_t src, prev_src;
	int                n_errors   = 0;
	int                n_tests    = 0;
	int                cyc        = 0;

	tss_top #(.OST_LIMIT(LIM)) dut (.mclk(mclk), .rstn(rstn), .ce(ce), .por_done(por_done),
		.power_up_timer_en(pwr_en), .power_up_timer_expired(pwr_exp),
		.sleep_exec(sleep_exec), .wake_event(wake_event), .switchover_enable(sw_en),
		.oscillator_mode_field(mode), .clock_select_field(cs), .ext_osc_tick(ext_tick),
		.t1_osc_tick(t1_tick), .sys_clk_src(src), .core_run(core_run),
		.ext_osc_en(ext_osc_en), .two_speed_active(ts_active), .start_up_done_flag(done_flag));
	tss_osc_model xosc (.mclk(mclk), .rstn(rstn), .en(ext_osc_en), .free_run(free),
		.slow(slow), .tick(ext_tick));
	tss_osc_model tosc (.mclk(mclk), .rstn(rstn), .en(ext_osc_en), .free_run(1'b0),
		.slow(1'b0), .tick(t1_tick));

	always #12.5 mclk = ~mclk;

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic rng(input string what, input int lo, input int hi, input int n);
		n_tests++;
		if (n < lo || n > hi) begin
			n_errors++;
			$display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, n);
		end
	endtask : rng

	task automatic do_reset(input logic sw, input logic [2:0] md, input logic [1:0] sel);
		@(negedge mclk);
		rstn     = 1'b0;
		por_done = 1'b0;
		pwr_en   = 1'b0;
		pwr_exp  = 1'b0;
		sw_en    = sw;
		mode     = md;
		cs       = sel;
		free     = (md == 3'h3) || (md > 3'h4);
		repeat (10) @(negedge mclk);
		chk("outputs in reset", 8'h00, {3'h0, src, core_run, ext_osc_en, done_flag});
		rstn = 1'b1;
	endtask : do_reset

	task automatic start_por();
		@(negedge mclk);
		por_done = 1'b1;
	endtask : start_por

	task automatic wait_src(input tss_pkg::tss_src_t want, input int lim, output int n);
		n = 0;
		while (src !== want && n < lim) begin
			@(negedge mclk);
			n++;
		end
	endtask : wait_src

	task automatic wait_leave(output int n);
		n = 0;
		while (src === tss_pkg::src_int && n < 500) begin
			@(negedge mclk);
			n++;
		end
	endtask : wait_leave

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_two_speed();
		int n;
		do_reset(1'b1, 3'h1, 2'h0);
		start_por();
		wait_src(tss_pkg::src_int, 200, n);
		rng("warm-up cycles", 80, 84, n);
		chk("internal run", 8'h07, {5'h00, core_run, ts_active, ext_osc_en});
		chk("flag early", 8'h00, {7'h00, done_flag});
		wait_leave(n);
		rng("internal cycles", LIM, LIM + 4, n);
		chk("swap gap", 8'h00, {6'h00, src});
		wait_src(tss_pkg::src_ext, 4, n);
		chk("external run", 8'h0B, {4'h0, src, core_run, done_flag});
		$display("test two_speed done");
	endtask : t_two_speed

	task automatic t_sleep();
		int n;
		do_reset(1'b1, 3'h2, 2'h0);
		start_por();
		wait_src(tss_pkg::src_int, 200, n);
		repeat (2) @(negedge mclk);
		sleep_exec = 1'b1;
		@(negedge mclk);
		sleep_exec = 1'b0;
		chk("sleep outputs", 8'h00, {3'h0, src, core_run, ext_osc_en, done_flag});
		repeat (LIM * 4) @(negedge mclk);
		chk("still asleep", 8'h00, {4'h0, src, core_run, done_flag});
		// Slow crystal: an unrestarted count would finish early
		slow       = 1'b1;
		wake_event = 1'b1;
		@(negedge mclk);
		wake_event = 1'b0;
		wait_src(tss_pkg::src_int, 200, n);
		rng("wake warm-up", 78, 84, n);
		wait_leave(n);
		rng("restarted count", 3 * LIM - 2, 3 * LIM + 4, n);
		wait_src(tss_pkg::src_ext, 4, n);
		chk("flag after wake", 8'h01, {7'h00, done_flag});
		slow = 1'b0;
		// Sleep from the external clock, then sleep on the final count
		sleep_exec = 1'b1;
		@(negedge mclk);
		sleep_exec = 1'b0;
		chk("sleep from external", 8'h00, {4'h0, src, core_run, ext_osc_en});
		wake_event = 1'b1;
		@(negedge mclk);
		wake_event = 1'b0;
		wait_src(tss_pkg::src_int, 200, n);
		rng("second wake warm-up", 78, 84, n);
		repeat (LIM) @(negedge mclk);
		sleep_exec = 1'b1;
		@(negedge mclk);
		sleep_exec = 1'b0;
		chk("sleep on last count", 8'h00, {5'h00, src, done_flag});
		$display("test sleep_abort done");
	endtask : t_sleep

	task automatic t_putimer();
		int n;
		do_reset(1'b1, 3'h1, 2'h0);
		@(negedge mclk);
		pwr_en     = 1'b1;
		por_done   = 1'b1;
		// Sleep and wake are refused while nothing runs
		sleep_exec = 1'b1;
		wake_event = 1'b1;
		@(negedge mclk);
		sleep_exec = 1'b0;
		wake_event = 1'b0;
		repeat (99) @(negedge mclk);
		chk("held by timer", 8'h00, {3'h0, src, core_run, ext_osc_en, ts_active});
		pwr_exp = 1'b1;
		wait_src(tss_pkg::src_int, 200, n);
		rng("start after timer", 80, 84, n);
		// Low enable must freeze the sequencer and the timer alike
		ce = 1'b0;
		repeat (30) @(negedge mclk);
		chk("frozen outputs", 8'h07, {5'h00, core_run, ts_active, ext_osc_en});
		chk("frozen source", 8'h01, {6'h00, src});
		ce = 1'b1;
		wait_leave(n);
		rng("count after freeze", LIM, LIM + 4, n);
		$display("test power_up_timer done");
	endtask : t_putimer

	task t_config();
		int                n;
		logic [2:0]        md [8]   = '{3'h3, 3'h5, 3'h6, 3'h7, 3'h4, 3'h1, 3'h0, 3'h2};
		logic [1:0]        sel [8]  = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h1};
		logic              sw [8]   = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
		tss_pkg::tss_src_t ex [8]   = '{tss_pkg::src_ext, tss_pkg::src_ext, tss_pkg::src_ext,
			tss_pkg::src_ext, tss_pkg::src_int, tss_pkg::src_int, tss_pkg::src_ext,
			tss_pkg::src_t1};
		int                lo [8]   = '{2, 2, 2, 2, 80, 80, LIM, LIM};
		int                fl [8]   = '{-1, -1, -1, -1, 0, 0, 1, 0};
		for (int i = 0; i < 8; i++) begin
			do_reset(sw[i], md[i], sel[i]);
			start_por();
			wait_src(ex[i], 200, n);
			rng("source delay", lo[i], lo[i] + 5, n);
			chk("source", {6'h00, ex[i]}, {6'h00, src});
			chk("two-speed off", 8'h00, {7'h00, ts_active});
			if (fl[i] >= 0) begin
				chk("done flag", 8'(fl[i]), {7'h00, done_flag});
			end
		end
		$display("test config_table done");
	endtask : t_config

	// --------------------------------------------------------------
	// Watchers and verdict
	// --------------------------------------------------------------
	always @(negedge mclk) begin
		prev_src <= src;
		if (rstn && prev_src === tss_pkg::src_int && src === tss_pkg::src_ext) begin
			n_errors++;
			$display("wrong value source swap expected gap seen direct");
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 8000) begin
			n_errors++;
			$display("wrong value cycle limit expected done seen hang");
			tally_and_finish();
		end
	end

	initial begin
		t_two_speed();
		t_sleep();
		t_putimer();
		t_config();
		tally_and_finish();
	end
endmodule : tb_two_speed_clock_startup

`default_nettype wire
